/* File: meter_pkg.sv */
// Shared constants for the panel meter result and display logic
package meter_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 200000; // 200 MHz core clock
  localparam int unsigned DONE_MS = 2; // Result update window
  localparam int unsigned DONE_CYC = DONE_MS * CLK_KHZ;
  localparam int unsigned CONV_MS = 100; // One conversion period
  localparam int unsigned CONV_CYC = CONV_MS * CLK_KHZ;
  localparam int unsigned SCAN_US = 250; // Dwell per display digit
  localparam int unsigned SCAN_CYC = SCAN_US * (CLK_KHZ / 1000);
  localparam int unsigned BLINK_MS = 250; // Half period of flashing
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;

  // Control bits, all active low like the pins they replace
  localparam int unsigned CTRL_HOLD_N = 0; // Freeze parallel outputs
  localparam int unsigned CTRL_BLANK_N = 1; // Display off
  localparam int unsigned CTRL_RUN_N = 2; // Conversion pause
  localparam logic [2:0] CTRL_RST = 3'h7;

  // Status bits
  localparam int unsigned ST_CONV = 0; // Conversion stored
  localparam int unsigned ST_OVR = 1; // Result above full scale
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // ----------------------------------------
  // Count limits, packed BCD
  // ----------------------------------------
  localparam logic [15:0] CNT_SAT = 16'h3000; // Counter stops here
  localparam logic [11:0] OVR_SHOW = 12'h999; // Fixed far-overrange show

endpackage : meter_pkg

/* File: bcd_counter.sv */
// Four-digit saturating BCD counter for the conversion count
module bcd_counter
  import meter_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic inc,
  output logic [15:0] bcd
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] dig; // d3 d2 d1 d0
  } cnt_state_t;

  cnt_state_t s_q; // Registered state
  cnt_state_t s_d; // Next state
  logic [4:0] carry; // Carry into each digit
  logic [15:0] nxt; // Incremented digits

  // Per-digit increment with decimal wrap
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      assign nxt[g*4 +: 4] = !carry[g] ? s_q.dig[g*4 +: 4] :
                             (s_q.dig[g*4 +: 4] == 4'h9) ? 4'h0 :
                             s_q.dig[g*4 +: 4] + 4'h1;
      assign carry[g+1] = carry[g] & (s_q.dig[g*4 +: 4] == 4'h9);
    end
  endgenerate

  assign carry[0] = 1'b1;
  assign bcd = s_q.dig;

  // Next state: clear wins, saturate instead of wrapping
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.dig = 16'h0000;
    end else if (inc && (s_q.dig != CNT_SAT)) begin
      s_d.dig = nxt;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : bcd_counter

/* File: seven_seg.sv */
// BCD to seven-segment decoder with blanking
module seven_seg (
  input wire logic [3:0] digit,
  input wire logic blank,
  output logic [6:0] seg
);

  // Segments g..a, active high; codes above nine show dark
  always_comb begin
    seg = 7'h00;
    if (!blank) begin
      case (digit)
        4'h0: seg = 7'h3f;
        4'h1: seg = 7'h06;
        4'h2: seg = 7'h5b;
        4'h3: seg = 7'h4f;
        4'h4: seg = 7'h66;
        4'h5: seg = 7'h6d;
        4'h6: seg = 7'h7d;
        4'h7: seg = 7'h07;
        4'h8: seg = 7'h7f;
        4'h9: seg = 7'h6f;
        default: seg = 7'h00;
      endcase
    end
  end

endmodule : seven_seg

/* File: meter_result_output_logic.sv */
// Panel meter digital processor: count, store, display and latched BCD
// Function
// - BCD valid except 2 ms done window
// - Freeze stops BCD updates, not conversions
// - Above 1999 counts display flashes
// - Counter measures on to about 3000
// - Top digit shows only one or blank
// - 2000-2999 shows three low digits flashing
// - Above 2999 shows fixed number flashing
// - Above 1999 BCD lines and overload low
// - Control, counting, storage and digit multiplexing
// - Stored result feeds decoder and BCD latch
// - Freeze is active low
// - Blanking hides digits, keeps decimal points
// - Pause stops conversions, display holds result
// - Latched positive-true BCD with status lines
//
// Register access over APB and the placing of the registers are this design's own decisions.
module meter_result_output_logic
  import meter_pkg::*;
#(
  parameter int unsigned CONV_CYC_P = CONV_CYC,
  parameter int unsigned DONE_CYC_P = DONE_CYC,
  parameter int unsigned SCAN_CYC_P = SCAN_CYC,
  parameter int unsigned BLINK_CYC_P = BLINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  input wire logic cmp_pulse,
  input wire logic pol_in,
  input wire logic [3:0] dp_n,
  // Parallel result port
  output logic [11:0] bcd_out,
  output logic over_out,
  output logic pol_out,
  output logic ovl_n,
  output logic data_ready,
  // Display and interrupt
  output logic [6:0] seg,
  output logic dp,
  output logic [3:0] dig_en,
  output logic irq
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [1:0] {COUNTING, READY, PAUSED} phase_t;

  typedef struct packed {
    phase_t phase; // Conversion sequencer
    logic [31:0] tmr; // Phase timer
    logic [15:0] res; // Stored result, BCD
    logic res_pol; // Stored polarity
    logic [2:0] ctrl; // Control register
    logic [1:0] stat; // Sticky events
    logic [1:0] mask; // Event enables
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] bcd; // Latched output digits
    logic over; // Latched half digit
    logic pol;
    logic ovl_n;
    logic rdy;
    logic [31:0] scan_tmr; // Multiplex divider
    logic [1:0] scan; // Digit being driven
    logic [31:0] blink_tmr; // Flash divider
    logic blink; // Flash phase, high is dark
    logic [6:0] seg;
    logic dp;
    logic [3:0] dig;
    logic irq;
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state
  logic cnt_clr; // Counter clear
  logic cnt_inc; // Counter step
  logic [15:0] cnt_bcd; // Running count
  logic [3:0] nib; // Scanned digit value
  logic nib_blank; // Scanned digit dark
  logic [6:0] seg_c; // Decoded segments

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  bcd_counter u_cnt (
    .clk(pclk),
    .rst_n(presetn),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .bcd(cnt_bcd)
  );

  seven_seg u_seg (
    .digit(nib),
    .blank(nib_blank),
    .seg(seg_c)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [1:0] ev; // Events this cycle
    logic [11:0] shown; // Low three digits to display
    logic hide_msd; // Top digit dark
    logic flash; // Result out of range
    logic setup; // APB setup phase
    logic acc; // APB completing access
    logic over_fs; // Stored result above 1999
    // Every local gets a value first so no path leaves a latch
    ev = 2'b00;
    shown = 12'h000;
    hide_msd = 1'b0;
    flash = 1'b0;
    setup = 1'b0;
    acc = 1'b0;
    over_fs = 1'b0;
    s_d = s_q;
    cnt_clr = 1'b0;
    cnt_inc = 1'b0;

    // Conversion sequencer
    case (s_q.phase)
      COUNTING: begin
        cnt_inc = cmp_pulse;
        s_d.tmr = s_q.tmr + 32'h1;
        if (!s_q.ctrl[CTRL_RUN_N]) begin
          // Pause drops the partial count; result stays on show
          s_d.phase = PAUSED;
          cnt_clr = 1'b1;
          s_d.tmr = 32'h0;
        end else if (s_q.tmr == 32'(CONV_CYC_P - 1)) begin
          s_d.res = cnt_bcd;
          s_d.res_pol = pol_in;
          cnt_clr = 1'b1;
          s_d.tmr = 32'h0;
          s_d.phase = READY;
          s_d.rdy = 1'b1;
          ev[ST_CONV] = 1'b1;
          // Thousands digit of two or more is out of range
          ev[ST_OVR] = (cnt_bcd[15:12] >= 4'h2);
        end
      end
      READY: begin
        s_d.tmr = s_q.tmr + 32'h1;
        if (s_q.tmr == 32'(DONE_CYC_P - 1)) begin
          s_d.tmr = 32'h0;
          s_d.rdy = 1'b0;
          s_d.phase = s_q.ctrl[CTRL_RUN_N] ? COUNTING : PAUSED;
          // Update latch only when freeze is high
          if (s_q.ctrl[CTRL_HOLD_N]) begin
            over_fs = (s_q.res[15:12] >= 4'h2);
            s_d.pol = s_q.res_pol;
            // Overrange zeroes the lines; polarity still follows
            if (over_fs) begin
              s_d.bcd = 12'h000;
              s_d.over = 1'b0;
              s_d.ovl_n = 1'b0;
            end else begin
              s_d.bcd = s_q.res[11:0];
              s_d.over = s_q.res[12];
              s_d.ovl_n = 1'b1;
            end
          end
        end
      end
      PAUSED: begin
        // Count held empty so release starts a whole fresh conversion
        cnt_clr = 1'b1;
        s_d.tmr = 32'h0;
        if (s_q.ctrl[CTRL_RUN_N]) begin
          s_d.phase = COUNTING;
        end
      end
      default: begin
        // Illegal code: park until the next release of the pause
        s_d.phase = PAUSED;
      end
    endcase

    // Multiplex and flash dividers
    // Both run free from reset, so the display keeps scanning
    // through pauses and freezes alike
    s_d.scan_tmr = s_q.scan_tmr + 32'h1;
    if (s_q.scan_tmr == 32'(SCAN_CYC_P - 1)) begin
      s_d.scan_tmr = 32'h0;
      s_d.scan = s_q.scan + 2'h1;
    end
    s_d.blink_tmr = s_q.blink_tmr + 32'h1;
    if (s_q.blink_tmr == 32'(BLINK_CYC_P - 1)) begin
      s_d.blink_tmr = 32'h0;
      s_d.blink = !s_q.blink;
    end

    // Display content from the stored result
    // Far overrange shows a fixed number so it cannot be misread
    shown = s_q.res[11:0];
    flash = 1'b0;
    hide_msd = (s_q.res[15:12] != 4'h1);
    if (s_q.res[15:12] >= 4'h3) begin
      shown = OVR_SHOW;
      flash = 1'b1;
      hide_msd = 1'b1;
    end else if (s_q.res[15:12] == 4'h2) begin
      flash = 1'b1;
      hide_msd = 1'b1;
    end
    // The top digit is only ever a one, so decode a constant
    nib = (s_q.scan == 2'h3) ? 4'h1 : shown[{s_q.scan, 2'b00} +: 4];
    // Blanking and the dark flash phase hit segments only; points stay
    nib_blank = !s_q.ctrl[CTRL_BLANK_N] | (flash & s_q.blink) |
                ((s_q.scan == 2'h3) & hide_msd);
    s_d.seg = seg_c;
    s_d.dig = 4'h1 << s_q.scan;
    s_d.dp = !dp_n[s_q.scan];

    // APB slave, answers in the first access cycle
    // Read data is captured at setup, so the access cycle only has to
    // hold the request steady; no wait states are ever added
    setup = psel & !penable;
    acc = psel & penable & s_q.pready;
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0;
      case (paddr)
        CTRL_OFS: s_d.prdata = {29'h0, s_q.ctrl};
        RESULT_OFS: s_d.prdata = {s_q.res, s_q.rdy, s_q.pol, s_q.ovl_n,
                                  s_q.over, s_q.bcd};
        STAT_OFS: s_d.prdata = {30'h0, s_q.stat};
        MASK_OFS: s_d.prdata = {30'h0, s_q.mask};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (acc && pwrite && !s_q.pslverr) begin
      if (paddr == CTRL_OFS) begin
        s_d.ctrl = pwdata[2:0];
      end
      if (paddr == MASK_OFS) begin
        s_d.mask = pwdata[1:0];
      end
    end
    // Read clears only bits returned; new events win
    // An event landing on the clearing read survives to the next read
    if (acc && !pwrite && (paddr == STAT_OFS)) begin
      s_d.stat = s_q.stat & ~s_q.prdata[1:0];
    end
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.phase <= COUNTING;
      s_q.ctrl <= CTRL_RST;
      s_q.stat <= STAT_RST;
      s_q.mask <= MASK_RST;
      s_q.ovl_n <= 1'b1;
      // Strobe starts on the lowest digit so it is one-hot from reset
      s_q.dig <= 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign bcd_out = s_q.bcd;
  assign over_out = s_q.over;
  assign pol_out = s_q.pol;
  assign ovl_n = s_q.ovl_n;
  assign data_ready = s_q.rdy;
  assign seg = s_q.seg;
  assign dp = s_q.dp;
  assign dig_en = s_q.dig;
  assign irq = s_q.irq;

endmodule : meter_result_output_logic

/* File: meter_props.sv */
// Port checker for the panel meter result logic
module meter_props #(
  parameter int unsigned DONE_CYC_P = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic data_ready,
  input wire logic over_out,
  input wire logic pol_out,
  input wire logic ovl_n,
  input wire logic [11:0] bcd_out,
  input wire logic [6:0] seg,
  input wire logic [3:0] dig_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Window length counter
  // ----------------------------------------
  logic [31:0] rc_q; // Cycles data_ready has been high
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Count the ready window; cleared while low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rc_q <= '0;
    else rc_q <= data_ready ? rc_q + 32'd1 : '0;
  end
  ready_len_a: assert property ($fell(data_ready) |-> rc_q == DONE_CYC_P)
    else $error("ready window length wrong");
  ready_max_a: assert property (data_ready |-> rc_q < DONE_CYC_P)
    else $error("ready window too long");
  bcd_latch_a: assert property (!$fell(data_ready) |-> $stable({bcd_out, over_out, ovl_n, pol_out}))
    else $error("outputs moved outside update edge");
  ovl_lines_a: assert property (!ovl_n |-> bcd_out == 12'h000 && !over_out)
    else $error("overload with nonzero lines");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  scan_onehot_a: assert property ($onehot(dig_en))
    else $error("digit strobe not one-hot");
  top_digit_a: assert property (dig_en[3] |-> seg == 7'h00 || seg == 7'h06)
    else $error("top digit not one or blank");
endmodule : meter_props
bind meter_result_output_logic meter_props #(.DONE_CYC_P(DONE_CYC_P)) meter_props_inst (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .data_ready,
  .over_out, .pol_out, .ovl_n, .bcd_out, .seg, .dig_en);

/* File: meter_reader.sv */
// External logic that captures the latched parallel result
module meter_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_ready,
  input wire logic ovl_n,
  input wire logic [11:0] bcd_out,
  output logic [12:0] snap
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sample only outside the update window, never mid-update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) snap <= '0;
    else if (!data_ready) snap <= {ovl_n, bcd_out};
  end
endmodule : meter_reader

/* File: tb_top.sv */
// Self-checking bench for the panel meter result logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import meter_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cmp_pulse = 0, pol_in = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, over_out, pol_out, ovl_n, data_ready, dp, irq, e;
  logic [3:0] dp_n = 4'h0, dig_en;
  logic [11:0] bcd_out;
  logic [6:0] seg;
  logic [12:0] snap;
  int mismatches = 0, n_tests = 0;
  always #2.5 pclk = ~pclk;
  meter_result_output_logic #(.CONV_CYC_P(3200), .DONE_CYC_P(20), .SCAN_CYC_P(4),
    .BLINK_CYC_P(10)) meter_result_output_logic_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cmp_pulse(cmp_pulse),
    .pol_in(pol_in),
    .dp_n(dp_n),
    .bcd_out(bcd_out),
    .over_out(over_out),
    .pol_out(pol_out),
    .ovl_n(ovl_n),
    .data_ready(data_ready),
    .seg(seg),
    .dp(dp),
    .dig_en(dig_en),
    .irq(irq)
  );
  meter_reader meter_reader_inst (.pclk, .presetn, .data_ready, .ovl_n, .bcd_out, .snap);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, then an idle cycle so psel never toggles twice a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task wdr(input logic v);
    do @(posedge pclk); while (data_ready !== v);
  endtask : wdr
  // Count n pulses in one conversion, then judge latched port and display
  // q is the expected {ovl_n, bcd}, c the stored count, po the latched polarity
  task meas(input int n, input logic p, input logic [12:0] q, input logic [15:0] c,
            input logic po);
    int dark;
    logic ov;
    dark = 0;
    ov = (c[15:12] == 4'h1);
    wdr(1);
    wdr(0);
    pol_in <= p;
    cmp_pulse <= 1;
    repeat (n) @(posedge pclk);
    cmp_pulse <= 0;
    wdr(1);
    wdr(0);
    @(posedge pclk);
    chk({ovl_n, over_out, bcd_out}, {q[12], ov, q[11:0]});
    chk(pol_out, po);
    chk(snap, q);
    chk({ovl_n, bcd_out}, {q[12], q[11:0]});
    apb(0, RESULT_OFS, 0);
    chk(r[31:16], c);
    chk(r[15:0], {1'b0, po, q[12], ov, q[11:0]});
    repeat (100) @(posedge pclk) if (dig_en[0] === 1 && seg === 7'h00) dark++;
    chk(dark != 0, n > 1999);
    $display("test meas %0d done", n);
  endtask : meas
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(0, CTRL_OFS, 0);
    chk(r[2:0], CTRL_RST);
    apb(0, 8'h10, 0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Frozen port keeps the earlier 567 while the new count is still stored
  task t_hold;
    apb(1, CTRL_OFS, 32'h6);
    meas(100, 1, {1'b1, 12'h567}, 16'h0100, 1'b0);
    apb(1, CTRL_OFS, 32'h7);
  endtask : t_hold
  task t_irq;
    apb(1, MASK_OFS, 32'h3);
    meas(2300, 1, 13'h0000, 16'h2300, 1'b1);
    chk(irq, 1);
    apb(0, STAT_OFS, 0);
    chk(r[1:0], 2'h3);
    @(posedge pclk);
    chk(irq, 0);
    apb(1, MASK_OFS, 0);
    $display("test irq done");
  endtask : t_irq
  // Pulses during the pause must be dropped and the stored count kept
  task t_pause;
    int k;
    k = 0;
    wdr(1);
    wdr(0);
    apb(1, CTRL_OFS, 32'h3);
    cmp_pulse <= 1;
    repeat (7000) @(posedge pclk) if (data_ready === 1) k++;
    cmp_pulse <= 0;
    chk(k, 0);
    apb(0, RESULT_OFS, 0);
    chk(r[31:16], 16'h0000);
    apb(1, CTRL_OFS, 32'h7);
    $display("test pause done");
  endtask : t_pause
  // Only the lowest digit asks for its point, so dp must follow that strobe
  task t_blank;
    int lit, pts;
    lit = 0;
    pts = 0;
    dp_n <= 4'he;
    apb(1, CTRL_OFS, 32'h5);
    repeat (40) @(posedge pclk) begin
      if (seg !== 7'h00) lit++;
      if (dp !== dig_en[0]) pts++;
    end
    chk(lit, 0);
    chk(pts, 0);
    apb(1, CTRL_OFS, 32'h7);
    repeat (20) @(posedge pclk) if (seg !== 7'h00) lit++;
    chk(lit != 0, 1);
    $display("test blank done");
  endtask : t_blank
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    meas(1234, 1, {1'b1, 12'h234}, 16'h1234, 1'b1);
    meas(567, 0, {1'b1, 12'h567}, 16'h0567, 1'b0);
    t_hold;
    t_irq;
    meas(3100, 0, 13'h0000, 16'h3000, 1'b0);
    t_pause;
    t_blank;
    end_sim;
  end
  // Hang guard well beyond the expected run
  initial begin
    #500000;
    mismatches++;
    end_sim;
  end
endmodule : tb_top
